// *** cie_cfg.svh ***
// constants of the instruction execute unit
`ifndef CIE_CFG_SVH
`define CIE_CFG_SVH

`define CIE_PC_W 13
`define CIE_DM_AW 10
`define CIE_STACK_DEPTH 8
`define CIE_SP_W 3
`define CIE_PC_RST 13'h0000
`define CIE_IRQ_VECTOR 13'h0004
`define CIE_ACC_RST 8'h00
`define CIE_ZERO_BYTE 8'h00
`define CIE_ONE_BYTE 8'h01
`define CIE_BCD_DIGIT_MAX 4'h9
`define CIE_BCD_LO_FIX 9'h006
`define CIE_BCD_HI_FIX 9'h060
`define CIE_ONE_PC 13'h0001

`endif

// *** cie_dmem.sv ***
// data memory model seen by the execute unit
`timescale 1ns/10ps
`include "cie_cfg.svh"
module cie_dmem (
   input wire logic clock,
   input wire logic [`CIE_DM_AW-1:0] dm_addr,
   input wire logic [7:0] dm_wdata,
   input wire logic dm_we,
   output logic [7:0] dm_rdata
);
   // unwritten bytes read as unknown, so a stray read shows up at once
   logic [7:0] mem [0:(1<<`CIE_DM_AW)-1];
   assign dm_rdata = mem[dm_addr];
   always @(posedge clock) begin
      if (dm_we) begin
         mem[dm_addr] <= dm_wdata;
      end
   end
endmodule

// *** cie_exec.sv ***
// execute unit for call, return, clear, complement, adjust, inc/dec, move,
// or, rotate left, watchdog clear and power down
//
// Contract
// RL1: call pushes pc+1, loads target, two cycles, no flags changed.
// RL2: clear byte writes 00 to addressed memory, no flags changed.
// RL3: clear bit zeroes one selected bit only, others kept, no flags.
// RL4: watchdog clear resets counter, clears timeout and power-down flags.
// RL5: complement inverts memory byte in place and updates zero flag.
// RL6: complement to accumulator loads inverse, memory kept, zero updated.
// RL7: decimal adjust adds 6 per nibble above 9 or carried; result to memory.
// RL8: decimal adjust touches only carry, set when sum exceeds 99.
// RL9: decrement subtracts one, updates zero; memory or accumulator form.
// RL10: increment adds one, updates zero; memory or accumulator form.
// RL11: power down stops, gates clock, clears watchdog, sets pd, clears to.
// RL12: jump loads target, two cycles with dummy cycle, no flags.
// RL13: moves copy memory/immediate to accumulator or accumulator to memory.
// RL14: no-operation only advances the program counter.
// RL15: or with memory or immediate, zero updated; memory form writes memory.
// RL16: return pops program counter, flags unchanged.
// RL17: return with value also loads immediate into accumulator.
// RL18: interrupt return pops program counter and sets global enable.
// RL19: pending interrupt at interrupt return is serviced before main code.
// RL20: rotate left moves bit 7 into bit 0, flags unchanged.
// RL21: all other instructions of this group take one cycle; those that write memory hold ready low for one more cycle.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "cie_cfg.svh"

module cie_exec (
   input wire logic clock,
   input wire logic rstn,
   input wire logic instr_valid,
   input wire logic [4:0] instr_op,
   input wire logic [`CIE_PC_W-1:0] instr_target,
   input wire logic [`CIE_DM_AW-1:0] instr_mem_addr,
   input wire logic [2:0] instr_bit,
   input wire logic [7:0] instr_imm,
   output logic instr_ready,
   output logic [`CIE_PC_W-1:0] pc,
   output logic [`CIE_DM_AW-1:0] dm_addr,
   input wire logic [7:0] dm_rdata,
   output logic [7:0] dm_wdata,
   output logic dm_we,
   input wire logic irq_pending,
   output logic irq_ack,
   input wire logic watchdog_timeout,
   input wire logic wake,
   output logic watchdog_clear,
   output logic prescaler_clear,
   output logic sys_clock_en,
   output logic [7:0] accumulator,
   output logic zero_flag,
   output logic carry_flag,
   output logic half_carry_flag,
   output logic timeout_flag,
   output logic powerdown_flag,
   output logic global_irq_enable,
   output logic [`CIE_SP_W-1:0] stack_level
);

   logic rst_sync1_reg;
   logic rst_sync2_reg;
   logic rst_n;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_sync1_reg <= 1'b0;
         rst_sync2_reg <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_sync2_reg <= rst_sync1_reg;
      end
   end
   assign rst_n = rst_sync2_reg;

   cie_pkg::cie_state_t state_reg;
   cie_pkg::cie_state_t state_next;
   cie_pkg::cie_op_t op;
   logic [`CIE_PC_W-1:0] pc_reg;
   logic [`CIE_PC_W-1:0] pc_next;
   logic [7:0] acc_reg;
   logic [7:0] acc_next;
   logic z_reg;
   logic z_next;
   logic c_reg;
   logic c_next;
   logic hc_reg;
   logic to_reg;
   logic to_next;
   logic pd_reg;
   logic pd_next;
   logic gie_reg;
   logic gie_next;
   logic [`CIE_SP_W-1:0] sp_reg;
   logic [`CIE_SP_W-1:0] sp_next;
   logic [`CIE_PC_W-1:0] stack_reg [`CIE_STACK_DEPTH];
   logic [7:0] wdata_reg;
   logic [7:0] wdata_next;
   logic [`CIE_DM_AW-1:0] waddr_reg;
   logic we_reg;
   logic we_next;
   logic wdc_reg;
   logic wdc_next;
   logic ack_reg;

   // decode
   wire running = state_reg == cie_pkg::ST_RUN;
   // an interrupt is taken only between instructions, never mid-pair
   wire irq_take = running && gie_reg && irq_pending;
   // nothing executes in the write-back cycle, while ready is low
   wire exec = running && !irq_take && !we_reg && instr_valid; // RL21
   wire is_call = exec && op == cie_pkg::OP_CALL;
   wire push = is_call || irq_take;
   wire [`CIE_PC_W-1:0] pc_inc = pc_reg + `CIE_ONE_PC;
   wire [`CIE_SP_W-1:0] sp_top = sp_reg - 1'b1;
   wire [`CIE_PC_W-1:0] pop_value = stack_reg[sp_top];
   wire [7:0] bit_mask = `CIE_ONE_BYTE << instr_bit;
   wire [7:0] mem_dec = dm_rdata - `CIE_ONE_BYTE;
   wire [7:0] mem_inc = dm_rdata + `CIE_ONE_BYTE;
   wire [7:0] mem_inv = ~dm_rdata;
   wire [7:0] or_mem = acc_reg | dm_rdata;
   wire [7:0] or_imm = acc_reg | instr_imm;
   wire [7:0] rot_left = {dm_rdata[6:0], dm_rdata[7]};

   // decimal adjust: low digit first, then high digit on the adjusted sum
   wire lo_fix = acc_reg[3:0] > `CIE_BCD_DIGIT_MAX || hc_reg;
   wire [8:0] daa_lo = {1'b0, acc_reg} + (lo_fix ? `CIE_BCD_LO_FIX : 9'h000);
   wire hi_fix = daa_lo[7:4] > `CIE_BCD_DIGIT_MAX || c_reg || daa_lo[8];
   wire [8:0] daa_sum = daa_lo + (hi_fix ? `CIE_BCD_HI_FIX : 9'h000);
   wire daa_carry = c_reg || daa_lo[8] || daa_sum[8];

   assign op = cie_pkg::cie_op_t'(instr_op);

   always_comb begin
      state_next = state_reg;
      pc_next = pc_reg;
      acc_next = acc_reg;
      z_next = z_reg;
      c_next = c_reg;
      to_next = to_reg | watchdog_timeout;
      pd_next = pd_reg;
      gie_next = gie_reg;
      sp_next = sp_reg;
      wdata_next = wdata_reg;
      we_next = 1'b0;
      wdc_next = 1'b0;
      unique case (state_reg)
         cie_pkg::ST_DUMMY: begin
            state_next = cie_pkg::ST_RUN; // RL1 RL12
         end
         cie_pkg::ST_HALT: begin
            if (wake) begin
               state_next = cie_pkg::ST_RUN;
            end
         end
         cie_pkg::ST_RUN: begin
            if (irq_take) begin
               pc_next = `CIE_IRQ_VECTOR; // RL19
               sp_next = sp_reg + 1'b1;
               gie_next = 1'b0;
               state_next = cie_pkg::ST_DUMMY;
            end else if (exec) begin
               pc_next = pc_inc; // RL14 RL21
               unique case (op)
                  cie_pkg::OP_CALL: begin
                     pc_next = instr_target; // RL1
                     sp_next = sp_reg + 1'b1;
                     state_next = cie_pkg::ST_DUMMY;
                  end
                  cie_pkg::OP_JUMP: begin
                     pc_next = instr_target; // RL12
                     state_next = cie_pkg::ST_DUMMY;
                  end
                  cie_pkg::OP_CLR_BYTE: begin
                     wdata_next = `CIE_ZERO_BYTE; // RL2
                     we_next = 1'b1;
                  end
                  cie_pkg::OP_CLR_BIT: begin
                     wdata_next = dm_rdata & ~bit_mask; // RL3
                     we_next = 1'b1;
                  end
                  cie_pkg::OP_CLR_WATCHDOG: begin
                     wdc_next = 1'b1; // RL4
                     to_next = watchdog_timeout;
                     pd_next = 1'b0;
                  end
                  cie_pkg::OP_INVERT: begin
                     wdata_next = mem_inv; // RL5
                     we_next = 1'b1;
                     z_next = mem_inv == `CIE_ZERO_BYTE;
                  end
                  cie_pkg::OP_INVERT_TO_ACC: begin
                     acc_next = mem_inv; // RL6
                     z_next = mem_inv == `CIE_ZERO_BYTE;
                  end
                  cie_pkg::OP_DECIMAL_ADJUST: begin
                     wdata_next = daa_sum[7:0]; // RL7
                     we_next = 1'b1;
                     c_next = daa_carry; // RL8
                  end
                  cie_pkg::OP_DEC: begin
                     wdata_next = mem_dec; // RL9
                     we_next = 1'b1;
                     z_next = mem_dec == `CIE_ZERO_BYTE;
                  end
                  cie_pkg::OP_DEC_TO_ACC: begin
                     acc_next = mem_dec; // RL9
                     z_next = mem_dec == `CIE_ZERO_BYTE;
                  end
                  cie_pkg::OP_INC: begin
                     wdata_next = mem_inc; // RL10
                     we_next = 1'b1;
                     z_next = mem_inc == `CIE_ZERO_BYTE;
                  end
                  cie_pkg::OP_INC_TO_ACC: begin
                     acc_next = mem_inc; // RL10
                     z_next = mem_inc == `CIE_ZERO_BYTE;
                  end
                  cie_pkg::OP_POWER_DOWN: begin
                     wdc_next = 1'b1; // RL11
                     pd_next = 1'b1;
                     to_next = watchdog_timeout;
                     state_next = cie_pkg::ST_HALT;
                  end
                  cie_pkg::OP_MOV_MEM_TO_ACC: begin
                     acc_next = dm_rdata; // RL13
                  end
                  cie_pkg::OP_MOV_IMM_TO_ACC: begin
                     acc_next = instr_imm; // RL13
                  end
                  cie_pkg::OP_MOV_ACC_TO_MEM: begin
                     wdata_next = acc_reg; // RL13
                     we_next = 1'b1;
                  end
                  cie_pkg::OP_OR_MEM: begin
                     acc_next = or_mem; // RL15
                     z_next = or_mem == `CIE_ZERO_BYTE;
                  end
                  cie_pkg::OP_OR_IMM: begin
                     acc_next = or_imm; // RL15
                     z_next = or_imm == `CIE_ZERO_BYTE;
                  end
                  cie_pkg::OP_OR_TO_MEMORY: begin
                     wdata_next = or_mem; // RL15
                     we_next = 1'b1;
                     z_next = or_mem == `CIE_ZERO_BYTE;
                  end
                  cie_pkg::OP_RETURN: begin
                     pc_next = pop_value; // RL16
                     sp_next = sp_top;
                  end
                  cie_pkg::OP_RETURN_IMM: begin
                     pc_next = pop_value; // RL16
                     sp_next = sp_top;
                     acc_next = instr_imm; // RL17
                  end
                  cie_pkg::OP_INTERRUPT_RETURN: begin
                     pc_next = pop_value; // RL18
                     sp_next = sp_top;
                     gie_next = 1'b1; // RL18
                  end
                  cie_pkg::OP_ROTATE_LEFT: begin
                     wdata_next = rot_left; // RL20
                     we_next = 1'b1;
                  end
                  cie_pkg::OP_NOP: begin
                     pc_next = pc_inc; // RL14
                  end
                  default: begin
                     pc_next = pc_inc;
                  end
               endcase
            end
         end
         default: begin
            state_next = cie_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= cie_pkg::ST_RUN;
         pc_reg <= `CIE_PC_RST;
         acc_reg <= `CIE_ACC_RST;
         z_reg <= 1'b0;
         c_reg <= 1'b0;
         hc_reg <= 1'b0;
         to_reg <= 1'b0;
         pd_reg <= 1'b0;
         gie_reg <= 1'b0;
         sp_reg <= '0;
      end else begin
         state_reg <= state_next;
         pc_reg <= pc_next;
         acc_reg <= acc_next;
         z_reg <= z_next;
         c_reg <= c_next;
         to_reg <= to_next;
         pd_reg <= pd_next;
         gie_reg <= gie_next;
         sp_reg <= sp_next;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wdata_reg <= `CIE_ZERO_BYTE;
         waddr_reg <= '0;
         we_reg <= 1'b0;
         wdc_reg <= 1'b0;
         ack_reg <= 1'b0;
      end else begin
         wdata_reg <= wdata_next;
         waddr_reg <= instr_mem_addr;
         we_reg <= we_next;
         wdc_reg <= wdc_next;
         ack_reg <= irq_take;
      end
   end

   // return stack: the call pushes the address after itself, an
   // interrupt pushes the address of the instruction it displaced
   genvar gi;
   generate
      for (gi = 0; gi < `CIE_STACK_DEPTH; gi++) begin : g_stack
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               stack_reg[gi] <= `CIE_PC_RST;
            end else if (push && sp_reg == gi) begin
               stack_reg[gi] <= irq_take ? pc_reg : pc_inc; // RL1
            end
         end
      end
   endgenerate

   // memory writes land one cycle late; the read address switches to the
   // write address for that cycle and ready stays low, so the next read always
   // sees the new data (no forwarding, kept small on purpose)
   assign dm_addr = we_reg ? waddr_reg : instr_mem_addr;
   assign dm_wdata = wdata_reg;
   assign dm_we = we_reg;
   assign instr_ready = running && !irq_take && !we_reg; // RL21
   assign pc = pc_reg;
   assign watchdog_clear = wdc_reg; // RL4 RL11
   assign prescaler_clear = wdc_reg; // RL11
   assign sys_clock_en = state_reg != cie_pkg::ST_HALT; // RL11
   assign irq_ack = ack_reg;
   assign accumulator = acc_reg;
   assign zero_flag = z_reg;
   assign carry_flag = c_reg;
   assign half_carry_flag = hc_reg;
   assign timeout_flag = to_reg;
   assign powerdown_flag = pd_reg;
   assign global_irq_enable = gie_reg;
   assign stack_level = sp_reg;

endmodule

// *** cie_exec_properties.sv ***
// assertions on the execute unit ports
`timescale 1ns/10ps
`include "cie_cfg.svh"
module cie_exec_properties (
   input wire logic clock,
   input wire logic rstn,
   input wire logic instr_valid,
   input wire logic instr_ready,
   input wire logic [4:0] instr_op,
   input wire logic [`CIE_PC_W-1:0] instr_target,
   input wire logic [2:0] instr_bit,
   input wire logic [7:0] dm_rdata,
   input wire logic [7:0] dm_wdata,
   input wire logic dm_we,
   input wire logic [`CIE_PC_W-1:0] pc,
   input wire logic [`CIE_SP_W-1:0] stack_level,
   input wire logic [7:0] accumulator,
   input wire logic zero_flag,
   input wire logic carry_flag,
   input wire logic timeout_flag,
   input wire logic powerdown_flag,
   input wire logic watchdog_timeout,
   input wire logic watchdog_clear,
   input wire logic prescaler_clear,
   input wire logic sys_clock_en,
   input wire logic irq_pending
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   logic tk;
   assign tk = instr_valid && instr_ready;
   property p_call;
      tk && instr_op == cie_pkg::OP_CALL |=> pc == $past(instr_target)
         && stack_level - $past(stack_level) == 3'h1 && !instr_ready;
   endproperty
   a_call: assert property (p_call) else $error("call wrong");
   property p_jump;
      tk && instr_op == cie_pkg::OP_JUMP |=> pc == $past(instr_target)
         && $stable(zero_flag) && !instr_ready;
   endproperty
   a_jump: assert property (p_jump) else $error("jump wrong");
   property p_clr_bit;
      tk && instr_op == cie_pkg::OP_CLR_BIT |=> dm_we
         && dm_wdata == ($past(dm_rdata) & ~(8'h01 << $past(instr_bit)));
   endproperty
   a_clr_bit: assert property (p_clr_bit) else $error("clr bit wrong");
   property p_invert;
      tk && instr_op == cie_pkg::OP_INVERT |=> dm_we
         && dm_wdata == ~$past(dm_rdata) && zero_flag == (dm_wdata == 8'h00);
   endproperty
   a_invert: assert property (p_invert) else $error("invert wrong");
   property p_inc_acc;
      tk && instr_op == cie_pkg::OP_INC_TO_ACC |=> !dm_we
         && accumulator == $past(dm_rdata) + 8'h01;
   endproperty
   a_inc_acc: assert property (p_inc_acc) else $error("inc wrong");
   property p_rotate;
      tk && instr_op == cie_pkg::OP_ROTATE_LEFT |=> dm_we
         && $stable(carry_flag)
         && dm_wdata == {$past(dm_rdata[6:0]), $past(dm_rdata[7])};
   endproperty
   a_rotate: assert property (p_rotate) else $error("rotate wrong");
   property p_power_down;
      tk && instr_op == cie_pkg::OP_POWER_DOWN |=> powerdown_flag
         && timeout_flag == $past(watchdog_timeout)
         && watchdog_clear && prescaler_clear && !sys_clock_en;
   endproperty
   a_power_down: assert property (p_power_down) else $error("pd wrong");
   property p_wdt_clear;
      tk && instr_op == cie_pkg::OP_CLR_WATCHDOG |=> watchdog_clear
         && !powerdown_flag && timeout_flag == $past(watchdog_timeout);
   endproperty
   a_wdt_clear: assert property (p_wdt_clear) else $error("wdt wrong");
   c_call: cover property (tk && instr_op == cie_pkg::OP_CALL);
   c_halt: cover property (tk && instr_op == cie_pkg::OP_POWER_DOWN);
   c_interrupt_return: cover property (tk && instr_op == cie_pkg::OP_INTERRUPT_RETURN
      && irq_pending);
endmodule
bind cie_exec cie_exec_properties u_props (.clock, .rstn, .instr_valid,
   .instr_ready, .instr_op, .instr_target, .instr_bit, .dm_rdata, .dm_wdata,
   .dm_we, .pc, .stack_level, .accumulator, .zero_flag, .carry_flag,
   .timeout_flag, .powerdown_flag, .watchdog_timeout, .watchdog_clear,
   .prescaler_clear, .sys_clock_en, .irq_pending);

// *** cie_pkg.sv ***
// types of the instruction execute unit
package cie_pkg;

   typedef enum logic [4:0] {
      OP_NOP = 5'h00,
      OP_CALL = 5'h01,
      OP_CLR_BYTE = 5'h02,
      OP_CLR_BIT = 5'h03,
      OP_CLR_WATCHDOG = 5'h04,
      OP_INVERT = 5'h05,
      OP_INVERT_TO_ACC = 5'h06,
      OP_DECIMAL_ADJUST = 5'h07,
      OP_DEC = 5'h08,
      OP_DEC_TO_ACC = 5'h09,
      OP_POWER_DOWN = 5'h0A,
      OP_INC = 5'h0B,
      OP_INC_TO_ACC = 5'h0C,
      OP_JUMP = 5'h0D,
      OP_MOV_MEM_TO_ACC = 5'h0E,
      OP_MOV_IMM_TO_ACC = 5'h0F,
      OP_MOV_ACC_TO_MEM = 5'h10,
      OP_OR_MEM = 5'h11,
      OP_OR_IMM = 5'h12,
      OP_OR_TO_MEMORY = 5'h13,
      OP_RETURN = 5'h14,
      OP_RETURN_IMM = 5'h15,
      OP_INTERRUPT_RETURN = 5'h16,
      OP_ROTATE_LEFT = 5'h17
   } cie_op_t;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_DUMMY = 3'b010,
      ST_HALT = 3'b100
   } cie_state_t;

endpackage

// *** testbench.sv ***
// self-checking bench of the execute unit against an integer model
`timescale 1ns/10ps
module testbench;
   logic clock = 0, rstn = 0, instr_valid = 0, irq_pending = 0, wake = 0;
   logic watchdog_timeout = 0, instr_ready, dm_we, irq_ack, watchdog_clear;
   logic prescaler_clear, sys_clock_en, zero_flag, carry_flag;
   logic half_carry_flag, timeout_flag, powerdown_flag, global_irq_enable;
   logic [4:0] instr_op = 0;
   logic [12:0] instr_target = 0, pc;
   logic [9:0] instr_mem_addr = 0, dm_addr;
   logic [2:0] instr_bit = 0, stack_level;
   logic [7:0] instr_imm = 0, dm_rdata, dm_wdata, accumulator;
   int err_total = 0, comparisons = 0, cyc = 0;
   logic [31:0] seed = 32'h56AB;
   logic [7:0] m_acc = 0, mm[int];
   logic m_z = 0, m_c = 0, m_to = 0, m_pd = 0, m_gie = 0;
   logic [12:0] m_pc = 0, stk[$];
   cie_pkg::cie_op_t ops[12] = '{cie_pkg::OP_NOP, cie_pkg::OP_CLR_BYTE,
      cie_pkg::OP_CLR_BIT, cie_pkg::OP_INVERT, cie_pkg::OP_INVERT_TO_ACC,
      cie_pkg::OP_DEC, cie_pkg::OP_DEC_TO_ACC, cie_pkg::OP_INC,
      cie_pkg::OP_INC_TO_ACC, cie_pkg::OP_MOV_MEM_TO_ACC, cie_pkg::OP_OR_MEM,
      cie_pkg::OP_ROTATE_LEFT};
   logic [7:0] bcd[4] = '{8'h15, 8'h1C, 8'hA3, 8'h9A};
   cie_exec dut (.clock, .rstn, .instr_valid, .instr_op, .instr_target,
      .instr_mem_addr, .instr_bit, .instr_imm, .instr_ready, .pc, .dm_addr,
      .dm_rdata, .dm_wdata, .dm_we, .irq_pending, .irq_ack, .watchdog_timeout,
      .wake, .watchdog_clear, .prescaler_clear, .sys_clock_en, .accumulator,
      .zero_flag, .carry_flag, .half_carry_flag, .timeout_flag,
      .powerdown_flag, .global_irq_enable, .stack_level);
   cie_dmem mem (.clock, .dm_addr, .dm_wdata, .dm_we, .dm_rdata);
   always #12.5 clock = ~clock;
   // ceiling well above the roughly 700 cycles the sequence needs
   always @(posedge clock) begin
      cyc++;
      if (cyc == 8000) begin
         err_total++;
         stop_test;
      end
   end
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task stop_test;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task chk(logic [31:0] got, logic [31:0] exp, string s);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   // model of one instruction, applied at the edge that takes it
   task model(cie_pkg::cie_op_t o, logic [9:0] a, logic [2:0] b,
         logic [7:0] x, logic [12:0] t);
      logic [7:0] rd, r;
      logic [8:0] w;
      logic zu;
      logic [12:0] nx;
      rd = mm[a];
      zu = 0;
      nx = m_pc + 13'h0001;
      case (o)
         cie_pkg::OP_CALL: begin stk.push_back(nx); nx = t; end
         cie_pkg::OP_CLR_BYTE: mm[a] = 8'h00;
         cie_pkg::OP_CLR_BIT: mm[a][b] = 1'h0;
         cie_pkg::OP_CLR_WATCHDOG: begin m_to = 0; m_pd = 0; end
         cie_pkg::OP_INVERT: begin r = ~rd; mm[a] = r; zu = 1; end
         cie_pkg::OP_INVERT_TO_ACC: begin r = ~rd; m_acc = r; zu = 1; end
         cie_pkg::OP_DECIMAL_ADJUST: begin
            w = {1'h0, m_acc};
            if (w[3:0] > 4'h9) w += 9'h006;
            if (w[8:4] > 5'h09 || m_c) begin w += 9'h060; m_c = 1; end
            mm[a] = w[7:0];
         end
         cie_pkg::OP_DEC: begin r = rd - 8'h01; mm[a] = r; zu = 1; end
         cie_pkg::OP_DEC_TO_ACC: begin r = rd - 8'h01; m_acc = r; zu = 1; end
         cie_pkg::OP_POWER_DOWN: begin m_pd = 1; m_to = 0; end
         cie_pkg::OP_INC: begin r = rd + 8'h01; mm[a] = r; zu = 1; end
         cie_pkg::OP_INC_TO_ACC: begin r = rd + 8'h01; m_acc = r; zu = 1; end
         cie_pkg::OP_JUMP: nx = t;
         cie_pkg::OP_MOV_MEM_TO_ACC: m_acc = rd;
         cie_pkg::OP_MOV_IMM_TO_ACC: m_acc = x;
         cie_pkg::OP_MOV_ACC_TO_MEM: mm[a] = m_acc;
         cie_pkg::OP_OR_MEM: begin r = m_acc | rd; m_acc = r; zu = 1; end
         cie_pkg::OP_OR_IMM: begin r = m_acc | x; m_acc = r; zu = 1; end
         cie_pkg::OP_OR_TO_MEMORY: begin r = m_acc | rd; mm[a] = r; zu = 1; end
         cie_pkg::OP_RETURN: nx = stk.pop_back();
         cie_pkg::OP_RETURN_IMM: begin nx = stk.pop_back(); m_acc = x; end
         cie_pkg::OP_INTERRUPT_RETURN: begin
            nx = stk.pop_back();
            m_gie = !irq_pending;
            if (irq_pending) begin stk.push_back(nx); nx = 13'h0004; end
         end
         cie_pkg::OP_ROTATE_LEFT: mm[a] = {rd[6:0], rd[7]};
         default: ;
      endcase
      if (zu) m_z = (r == 8'h00);
      m_pc = nx;
   endtask
   task run(cie_pkg::cie_op_t o, logic [9:0] a, logic [2:0] b,
         logic [7:0] x, logic [12:0] t);
      int n;
      @(posedge clock);
      instr_op <= o;
      instr_mem_addr <= a;
      instr_bit <= b;
      instr_imm <= x;
      instr_target <= t;
      instr_valid <= 1'h1;
      n = 0;
      do @(negedge clock); while (instr_ready !== 1'h1 && n++ < 20);
      @(posedge clock);
      instr_valid <= 1'h0;
      model(o, a, b, x, t);
      repeat (2) @(negedge clock);
      chk(accumulator, m_acc, "acc");
      chk(zero_flag, m_z, "zero");
      chk({carry_flag, half_carry_flag}, {m_c, 1'h0}, "carry");
      chk(timeout_flag, m_to, "timeout");
      chk(powerdown_flag, m_pd, "powerdown");
      chk(global_irq_enable, m_gie, "irq enable");
      chk(pc, m_pc, "pc");
      chk(stack_level, stk.size(), "stack");
      chk(mem.mem[a], mm[a], "memory");
   endtask
   initial begin
      for (int i = 0; i < 16; i++) begin
         mm[i] = rnd();
         mem.mem[i] = mm[i];
      end
      repeat (3) @(posedge clock);
      rstn <= 1'h1;
      repeat (3) @(posedge clock);
      run(cie_pkg::OP_CALL, 0, 0, 0, 13'h0123);
      run(cie_pkg::OP_MOV_IMM_TO_ACC, 0, 0, 8'hF0, 0);
      run(cie_pkg::OP_RETURN_IMM, 0, 0, 8'h00, 0);
      run(cie_pkg::OP_OR_TO_MEMORY, 3, 0, 0, 0);
      run(cie_pkg::OP_OR_IMM, 0, 0, 8'h00, 0);
      run(cie_pkg::OP_CALL, 0, 0, 0, 13'h1FFF);
      @(posedge clock);
      irq_pending <= 1'h1;
      run(cie_pkg::OP_INTERRUPT_RETURN, 0, 0, 0, 0);
      chk(irq_ack, 1'h1, "irq ack");
      @(posedge clock);
      irq_pending <= 1'h0;
      run(cie_pkg::OP_RETURN, 0, 0, 0, 0);
      run(cie_pkg::OP_JUMP, 0, 0, 0, 13'h0800);
      run(cie_pkg::OP_CALL, 0, 0, 0, 13'h0040);
      run(cie_pkg::OP_INTERRUPT_RETURN, 0, 0, 0, 0);
      // bcd sums: none, low fix, high fix with carry out, both with carry kept
      for (int i = 0; i < 4; i++) begin
         run(cie_pkg::OP_MOV_IMM_TO_ACC, 0, 0, bcd[i], 0);
         run(cie_pkg::OP_DECIMAL_ADJUST, 5, 0, 0, 0);
      end
      @(posedge clock);
      watchdog_timeout <= 1'h1;
      @(posedge clock);
      watchdog_timeout <= 1'h0;
      m_to = 1;
      run(cie_pkg::OP_POWER_DOWN, 0, 0, 0, 0);
      chk(sys_clock_en, 1'h0, "clock gate");
      @(posedge clock);
      wake <= 1'h1;
      @(posedge clock);
      wake <= 1'h0;
      run(cie_pkg::OP_CLR_WATCHDOG, 0, 0, 0, 0);
      run(cie_pkg::OP_MOV_ACC_TO_MEM, 15, 0, 0, 0);
      for (int k = 0; k < 200; k++) begin
         run(ops[rnd() % 12], rnd() % 16, rnd(), rnd(), 0);
      end
      stop_test;
   end
endmodule
